/* File: src/spi_flash_command_engine.sv */
`timescale 1ns/1ps
// Function
// - Instruction starts at chip select fall; input sampled on rising SCK, MSB first.
// - Every bus cycle is one byte of exactly eight SCK periods.
// - Only address bits 15..0 matter; upper address byte is ignored.
// - Dummy input bytes are disregarded whatever their level.
// - Read 03h plus three address bytes streams data until chip select rises.
// - Read pointer increments per byte and wraps from top to zero.
// - Byte program 02h, address, data; programming starts at chip select rise.
// - Program or erase aimed at a protected area is ignored, except block erase when only c000 up is protected.
// - Auto-increment AFh, address, data; first byte programs at chip select rise.
// - Later auto-increment frames carry AFh and data; next sequential address.
// - Write disable 04h ends auto-increment; host polls until done.
// - Auto-increment never wraps; at top unprotected address exit and clear latch.
// - Sector erase 20h clears the 4 KByte sector chosen by bits 15..12.
// - Block erase 52h clears the 32 KByte block chosen by bit 15.
// - Chip erase 60h clears everything, ignored if any area protected.
// - Program and erase begin only when chip select rises after final bit.
// - Status readable any time; byte repeats until chip select rises.
// - Write enable sets the latch at chip select rise unless busy; program and erase need it, status write does not.
// - Write disable clears latch and auto-increment flag at chip select rise.
// - Status write must directly follow the arm instruction to take effect.
// - Identification read: bit 0 picks maker or device code, alternating.
// - Status bit 0 busy, bit 1 latch, bit 6 auto-increment flag.
module spi_flash_command_engine
    import flash_cmd_pkg::*;
#(
    parameter int BYTE_PROGRAM_TIME_NS = DEF_BYTE_PROGRAM_TIME_NS,
    parameter int SECTOR_ERASE_TIME_NS = DEF_SECTOR_ERASE_TIME_NS,
    parameter int BLOCK_ERASE_TIME_NS = DEF_BLOCK_ERASE_TIME_NS,
    parameter int CHIP_ERASE_TIME_NS = DEF_CHIP_ERASE_TIME_NS,
    // Arbitrary identification values
    parameter logic [7:0] MAKER_CODE = 8'h5a,
    parameter logic [7:0] DEVICE_CODE = 8'h3c
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    output logic status_busy,
    output logic status_wel,
    output logic status_aai
);
    localparam int PROG_CYC = (BYTE_PROGRAM_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int SECT_CYC = (SECTOR_ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int BLK_CYC = (BLOCK_ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int CHIP_CYC = (CHIP_ERASE_TIME_NS * CLK_MHZ + 999) / 1000;

    // Written on clk_sys by the sequencer whatever chip select does; read on SCK
    logic [7:0] mem [0:MEM_BYTES-1];

    // Link side, SCK domain
    logic fresh_reg;
    logic [2:0] bit_reg;
    logic [2:0] byte_reg;
    logic [7:0] shift_reg;
    logic [7:0] opcode_reg;
    logic [15:0] addr_reg;
    logic [7:0] data_reg;
    logic frame_tog_reg;
    logic [7:0] stat_meta_reg;
    logic [7:0] stat_sync_reg;
    logic [7:0] obuf_reg;
    logic [15:0] ptr_reg;
    logic id_sel_reg;
    logic [2:0] bit_base;
    logic [2:0] byte_base;
    logic [7:0] shift_next;
    logic out_read;
    logic out_id;
    logic out_stat;
    logic out_first;
    logic [15:0] ptr_src;
    logic id_src;
    logic [7:0] out_byte;

    // System side
    logic cs_meta_reg;
    logic cs_sync_reg;
    logic cs_prev_reg;
    logic tog_seen_reg;
    logic wel_reg;
    logic aai_reg;
    logic arm_reg;
    logic bpl_reg;
    logic [1:0] bp_reg;
    logic [7:0] status_reg;
    engine_state_e state_reg;
    logic [31:0] timer_reg;
    logic [15:0] wr_addr_reg;
    logic [7:0] wr_data_reg;
    logic [15:0] er_last_reg;
    logic [15:0] aai_addr_reg;
    logic op_aai_reg;
    logic frame_done;
    logic busy;
    logic do_write_enable_cmd;
    logic do_write_disable_cmd;
    logic do_arm;
    logic do_status_write_cmd;
    logic do_prog;
    logic do_aai_first;
    logic do_aai_next;
    logic do_sect;
    logic do_blk;
    logic do_chip;
    logic op_done;
    logic [15:0] aai_top;
    logic [15:0] sect_base;
    logic [15:0] blk_base;

    function automatic logic is_protected(input logic [1:0] bp, input logic [15:0] a,
                                          input logic blk);
        logic p;
        p = 1'b0;
        case (bp)
            2'h0: p = 1'b0;
            2'h1: p = !blk && (a >= PROT_L1_BASE);
            2'h2: p = (a >= PROT_L2_BASE);
            default: p = 1'b1;
        endcase
        return p;
    endfunction

    // Frame start: counters restart on the first edge after chip select falls
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            fresh_reg <= 1'b1;
        end else begin
            fresh_reg <= 1'b0;
        end
    end

    assign bit_base = fresh_reg ? 3'h0 : bit_reg;
    assign byte_base = fresh_reg ? 3'h0 : byte_reg;
    assign shift_next = {shift_reg[6:0], spi_mosi};

    // Counters keep their last value after the frame so clk_sys can judge it
    always_ff @(posedge spi_sck) begin
        shift_reg <= shift_next;
        bit_reg <= bit_base + 3'h1;
        if (bit_base == 3'h7) begin
            data_reg <= shift_next;
            if (byte_base != LEN_MAX) begin
                byte_reg <= byte_base + 3'h1;
            end else begin
                byte_reg <= byte_base;
            end
            if (byte_base == 3'h0) begin
                opcode_reg <= shift_next;
            end
            // Upper address byte is never stored
            if (byte_base == BYTE_ADDR_HI) begin
                addr_reg[15:8] <= shift_next;
            end
            if (byte_base == BYTE_ADDR_LO) begin
                addr_reg[7:0] <= shift_next;
            end
        end else begin
            byte_reg <= byte_base;
        end
    end

    always_ff @(posedge spi_sck or posedge reset) begin
        if (reset) begin
            frame_tog_reg <= 1'b0;
        end else if (fresh_reg) begin
            frame_tog_reg <= ~frame_tog_reg;
        end
    end

    // Status bits are independent levels, so a per-bit sync is enough
    always_ff @(posedge spi_sck) begin
        stat_meta_reg <= status_reg;
        stat_sync_reg <= stat_meta_reg;
    end

    assign out_read = (opcode_reg == OP_READ) && (byte_reg >= LEN_OPCODE_ADDR);
    assign out_id = ((opcode_reg == OP_ID_READ_A) || (opcode_reg == OP_ID_READ_B)) &&
                    (byte_reg >= LEN_OPCODE_ADDR);
    assign out_stat = (opcode_reg == OP_STATUS_READ_CMD) && (byte_reg >= LEN_OPCODE_ONLY);
    assign out_first = (byte_reg == LEN_OPCODE_ADDR);
    assign ptr_src = out_first ? addr_reg : ptr_reg;
    assign id_src = out_first ? addr_reg[0] : id_sel_reg;

    always_comb begin
        out_byte = 8'h00;
        if (out_read) begin
            out_byte = mem[ptr_src];
        end else if (out_id) begin
            out_byte = id_src ? DEVICE_CODE : MAKER_CODE;
        end else if (out_stat) begin
            out_byte = stat_sync_reg;
        end
    end

    // Output shifts on falling SCK; released at once when chip select rises
    always_ff @(negedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            spi_miso_oe_n <= 1'b1;
            spi_miso <= 1'b0;
            obuf_reg <= 8'h00;
            ptr_reg <= 16'h0000;
            id_sel_reg <= 1'b0;
        end else if (!fresh_reg && bit_reg == 3'h0 && (out_read || out_id || out_stat)) begin
            spi_miso_oe_n <= 1'b0;
            spi_miso <= out_byte[7];
            obuf_reg <= {out_byte[6:0], 1'b0};
            ptr_reg <= ptr_src + 16'h0001;
            id_sel_reg <= ~id_src;
        end else begin
            spi_miso <= obuf_reg[7];
            obuf_reg <= {obuf_reg[6:0], 1'b0};
        end
    end

    // Chip select into clk_sys
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
        end else if (clk_en) begin
            cs_meta_reg <= spi_cs_n;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
        end
    end

    // Frame fields are stable once chip select is high and SCK is quiet
    assign frame_done = cs_sync_reg && !cs_prev_reg && (frame_tog_reg != tog_seen_reg) &&
                        (bit_reg == 3'h0) && clk_en;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tog_seen_reg <= 1'b0;
        end else if (frame_done) begin
            tog_seen_reg <= frame_tog_reg;
        end
    end

    assign busy = (state_reg != ST_IDLE);
    assign aai_top = (bp_reg == 2'h1) ? (PROT_L1_BASE - 16'h0001) :
                     (bp_reg == 2'h2) ? (PROT_L2_BASE - 16'h0001) : ADDR_TOP;
    assign sect_base = {addr_reg[15:12], 12'h000};
    assign blk_base = {addr_reg[15], 15'h0000};

    // Decode of a completed frame
    always_comb begin
        do_write_enable_cmd = frame_done && !busy && opcode_reg == OP_WRITE_ENABLE_CMD &&
                  byte_reg == LEN_OPCODE_ONLY;
        do_write_disable_cmd = frame_done && opcode_reg == OP_WRITE_DISABLE_CMD &&
                  byte_reg == LEN_OPCODE_ONLY;
        do_arm = frame_done && opcode_reg == OP_STATUS_WRITE_ARM_CMD &&
                 byte_reg == LEN_OPCODE_ONLY;
        do_status_write_cmd = frame_done && !busy && arm_reg && opcode_reg == OP_STATUS_WRITE_CMD &&
                  byte_reg == LEN_OPCODE_DATA;
        do_prog = frame_done && !busy && wel_reg && !aai_reg &&
                  opcode_reg == OP_BYTE_PROGRAM && byte_reg == LEN_OPCODE_ADDR_DATA &&
                  !is_protected(bp_reg, addr_reg, 1'b0);
        do_aai_first = frame_done && !busy && wel_reg && !aai_reg &&
                       opcode_reg == OP_AUTO_INCREMENT_PROGRAM &&
                       byte_reg == LEN_OPCODE_ADDR_DATA &&
                       !is_protected(bp_reg, addr_reg, 1'b0);
        do_aai_next = frame_done && !busy && wel_reg && aai_reg &&
                      opcode_reg == OP_AUTO_INCREMENT_PROGRAM &&
                      byte_reg == LEN_OPCODE_DATA;
        do_sect = frame_done && !busy && wel_reg && !aai_reg &&
                  opcode_reg == OP_SECTOR_ERASE && byte_reg == LEN_OPCODE_ADDR &&
                  !is_protected(bp_reg, sect_base, 1'b0);
        do_blk = frame_done && !busy && wel_reg && !aai_reg &&
                 opcode_reg == OP_BLOCK_ERASE && byte_reg == LEN_OPCODE_ADDR &&
                 !is_protected(bp_reg, blk_base, 1'b1);
        do_chip = frame_done && !busy && wel_reg && !aai_reg &&
                  opcode_reg == OP_CHIP_ERASE && byte_reg == LEN_OPCODE_ONLY &&
                  bp_reg == 2'h0;
    end

    assign op_done = (state_reg == ST_WAIT) && (timer_reg == 32'h0) && clk_en;

    // Self-timed sequencer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            timer_reg <= 32'h0;
            wr_addr_reg <= 16'h0000;
            wr_data_reg <= 8'h00;
            er_last_reg <= 16'h0000;
            op_aai_reg <= 1'b0;
        end else if (clk_en) begin
            if (timer_reg != 32'h0) begin
                timer_reg <= timer_reg - 32'h1;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (do_prog || do_aai_first || do_aai_next) begin
                        state_reg <= ST_PROG;
                        timer_reg <= 32'(PROG_CYC);
                        wr_addr_reg <= do_aai_next ? aai_addr_reg : addr_reg;
                        wr_data_reg <= data_reg;
                        op_aai_reg <= !do_prog;
                    end else if (do_sect || do_blk || do_chip) begin
                        state_reg <= ST_ERASE;
                        op_aai_reg <= 1'b0;
                        if (do_sect) begin
                            timer_reg <= 32'(SECT_CYC);
                            wr_addr_reg <= sect_base;
                            er_last_reg <= sect_base | SECTOR_LAST;
                        end else if (do_blk) begin
                            timer_reg <= 32'(BLK_CYC);
                            wr_addr_reg <= blk_base;
                            er_last_reg <= blk_base | BLOCK_LAST;
                        end else begin
                            timer_reg <= 32'(CHIP_CYC);
                            wr_addr_reg <= 16'h0000;
                            er_last_reg <= ADDR_TOP;
                        end
                    end
                end
                ST_PROG: begin
                    state_reg <= ST_WAIT;
                end
                ST_ERASE: begin
                    if (wr_addr_reg == er_last_reg) begin
                        state_reg <= ST_WAIT;
                    end else begin
                        wr_addr_reg <= wr_addr_reg + 16'h0001;
                    end
                end
                ST_WAIT: begin
                    if (timer_reg == 32'h0) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Programming can only clear bits, as in a real cell
    always_ff @(posedge clk_sys) begin
        if (clk_en && !reset) begin
            if (state_reg == ST_PROG) begin
                mem[wr_addr_reg] <= mem[wr_addr_reg] & wr_data_reg;
            end else if (state_reg == ST_ERASE) begin
                mem[wr_addr_reg] <= ERASED;
            end
        end
    end

    // Write enable latch
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wel_reg <= 1'b0;
        end else if (clk_en) begin
            if (do_write_enable_cmd) begin
                wel_reg <= 1'b1;
            end else if (do_write_disable_cmd) begin
                wel_reg <= 1'b0;
            end else if (op_done && (!op_aai_reg || wr_addr_reg == aai_top)) begin
                wel_reg <= 1'b0;
            end
        end
    end

    // Auto-increment mode and its running address
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            aai_reg <= 1'b0;
            aai_addr_reg <= 16'h0000;
        end else if (clk_en) begin
            if (do_write_disable_cmd) begin
                aai_reg <= 1'b0;
            end else if (do_aai_first) begin
                aai_reg <= 1'b1;
            end else if (op_done && op_aai_reg) begin
                aai_addr_reg <= wr_addr_reg + 16'h0001;
                if (wr_addr_reg == aai_top) begin
                    aai_reg <= 1'b0;
                end
            end
        end
    end

    // Arm holds only until the very next completed frame
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            arm_reg <= 1'b0;
        end else if (frame_done) begin
            arm_reg <= do_arm;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bp_reg <= BP_RESET;
            bpl_reg <= 1'b0;
        end else if (do_status_write_cmd) begin
            bp_reg <= {data_reg[ST_BP1], data_reg[ST_BP0]};
            bpl_reg <= data_reg[ST_BPL];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status_reg <= 8'h00;
            status_busy <= 1'b0;
            status_wel <= 1'b0;
            status_aai <= 1'b0;
        end else if (clk_en) begin
            status_reg <= {bpl_reg, aai_reg, 2'b00, bp_reg[1], bp_reg[0], wel_reg,
                           busy};
            status_busy <= busy;
            status_wel <= wel_reg;
            status_aai <= aai_reg;
        end
    end
endmodule

/* File: shared/flash_cmd_pkg.sv */
package flash_cmd_pkg;
    // Opcodes
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_BYTE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_AUTO_INCREMENT_PROGRAM = 8'haf;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'h52;
    localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
    localparam logic [7:0] OP_STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE_ARM_CMD = 8'h50;
    localparam logic [7:0] OP_STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] OP_ID_READ_A = 8'h90;
    localparam logic [7:0] OP_ID_READ_B = 8'hab;

    // Bytes per complete instruction
    localparam logic [2:0] LEN_OPCODE_ONLY = 3'h1;
    localparam logic [2:0] LEN_OPCODE_DATA = 3'h2;
    localparam logic [2:0] LEN_OPCODE_ADDR = 3'h4;
    localparam logic [2:0] LEN_OPCODE_ADDR_DATA = 3'h5;
    localparam logic [2:0] LEN_MAX = 3'h7;
    localparam logic [2:0] BYTE_ADDR_HI = 3'h2;
    localparam logic [2:0] BYTE_ADDR_LO = 3'h3;

    // Status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_BP0 = 2;
    localparam int ST_BP1 = 3;
    localparam int ST_AAI = 6;
    localparam int ST_BPL = 7;
    localparam logic [1:0] BP_RESET = 2'h3;

    // Array geometry, 16 significant address bits
    localparam int ADDR_W = 16;
    localparam int MEM_BYTES = 65536;
    localparam logic [15:0] ADDR_TOP = 16'hffff;
    localparam logic [15:0] PROT_L1_BASE = 16'hc000;
    localparam logic [15:0] PROT_L2_BASE = 16'h8000;
    localparam logic [15:0] SECTOR_LAST = 16'h0fff;
    localparam logic [15:0] BLOCK_LAST = 16'h7fff;
    localparam logic [7:0] ERASED = 8'hff;

    // Clock and default self-timed durations
    localparam int CLK_MHZ = 200;
    localparam int DEF_BYTE_PROGRAM_TIME_NS = 10000;
    localparam int DEF_SECTOR_ERASE_TIME_NS = 1000000;
    localparam int DEF_BLOCK_ERASE_TIME_NS = 1000000;
    localparam int DEF_CHIP_ERASE_TIME_NS = 2000000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_PROG = 4'b0010,
        ST_ERASE = 4'b0100,
        ST_WAIT = 4'b1000
    } engine_state_e;
endpackage

/* File: sim/spi_flash_command_engine_properties.sv */
`timescale 1ns/1ps
module spi_flash_command_engine_checker (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe_n,
    input wire logic status_busy,
    input wire logic status_wel,
    input wire logic status_aai
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence cs_quiet;
        spi_cs_n ##1 spi_cs_n;
    endsequence
    sequence write_launch;
        $rose(status_busy);
    endsequence
    a_oe_idle_cs: assert property (spi_cs_n |-> spi_miso_oe_n)
        else $error("output enabled while deselected");
    a_miso_idle_low: assert property (cs_quiet |-> !spi_miso)
        else $error("serial out not low while deselected");
    a_busy_after_cs: assert property (write_launch |-> cs_quiet)
        else $error("write began inside a frame");
    a_busy_needs_wel: assert property (write_launch |-> $past(status_wel))
        else $error("write began without latch");
    a_wel_done_clear: assert property ($fell(status_busy) && !status_aai |-> !status_wel)
        else $error("latch left set after write");
    a_aai_needs_wel: assert property (status_aai |-> status_wel)
        else $error("auto mode without latch");
    a_wel_rise_idle: assert property ($rose(status_wel) |-> spi_cs_n && !status_busy)
        else $error("latch set at wrong moment");
    a_aai_starts_prog: assert property ($rose(status_aai) |-> ##[0:3] status_busy)
        else $error("auto mode without program");
    a_freeze_holds: assert property (!clk_en |=> $stable({status_busy, status_wel, status_aai}))
        else $error("status moved while frozen");
endmodule
bind spi_flash_command_engine spi_flash_command_engine_checker u_chk (.clk_sys(clk_sys),
    .reset(reset), .clk_en(clk_en), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
    .status_busy(status_busy), .status_wel(status_wel), .status_aai(status_aai));

/* File: sim/spi_host_model.sv */
`timescale 1ns/1ps
module spi_host_model (
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso
);
    logic [7:0] rx_q[$];
    // Late start so the deselect edge reaches processes already waiting
    initial begin
        #1;
        spi_cs_n = 1'b1;
        spi_sck = 1'b0;
        spi_mosi = 1'b0;
    end
    // Clock stands low between frames; dummy bytes carry a pattern
    task automatic frame(input logic [7:0] tx[$], input int n_in);
        logic [7:0] b;
        rx_q.delete();
        #16 spi_cs_n = 1'b0;
        for (int i = 0; i < tx.size() + n_in; i++) begin
            b = (i < tx.size()) ? tx[i] : 8'h96;
            for (int k = 7; k >= 0; k--) begin
                spi_mosi = b[k];
                #16 b[k] = spi_miso;
                spi_sck = 1'b1;
                #16 spi_sck = 1'b0;
            end
            if (i >= tx.size()) rx_q.push_back(b);
        end
        #16 spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        #64;
    endtask
endmodule

/* File: sim/spi_flash_command_engine_tb.sv */
`timescale 1ns/1ps
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module spi_flash_command_engine_tb;
    import flash_cmd_pkg::*;
    localparam logic [7:0] maker_id = 8'h96; // Arbitrary value
    localparam logic [7:0] device_id = 8'h69; // Arbitrary value
    logic clk_sys, reset, clk_en, spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
    logic status_busy, status_wel, status_aai;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    spi_flash_command_engine #(.BYTE_PROGRAM_TIME_NS(100), .SECTOR_ERASE_TIME_NS(100),
        .BLOCK_ERASE_TIME_NS(100), .CHIP_ERASE_TIME_NS(100), .MAKER_CODE(maker_id),
        .DEVICE_CODE(device_id)) dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
        .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe_n(spi_miso_oe_n), .status_busy(status_busy), .status_wel(status_wel),
        .status_aai(status_aai));
    spi_host_model host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic cmd(input logic [7:0] tx[$]);
        host.frame(tx, 0);
    endtask
    task automatic expect_bytes(input logic [7:0] tx[$], input logic [7:0] exp[$]);
        host.frame(tx, exp.size());
        foreach (exp[i]) `CHECK(host.rx_q[i], exp[i])
    endtask
    // Long erase needs a wide bound; busy only shows a few clocks after deselect
    task automatic wait_idle(input int limit);
        int n;
        n = 0;
        repeat (8) @(posedge clk_sys);
        while (status_busy !== 1'b0 && n < limit) begin
            @(posedge clk_sys);
            n++;
        end
        `CHECK(status_busy, 1'b0)
    endtask
    initial begin
        // Rise after time zero so the asynchronous frame reset sees its edge
        reset = 1'b0;
        clk_en = 1'b1;
        #1 reset = 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        expect_bytes('{OP_STATUS_READ_CMD}, '{8'h0c, 8'h0c});
        cmd('{OP_WRITE_ENABLE_CMD});
        `CHECK(status_wel, 1'b1)
        cmd('{OP_CHIP_ERASE});
        cmd('{OP_BYTE_PROGRAM, 8'h00, 8'h00, 8'h00, 8'h00});
        `CHECK(status_busy, 1'b0)
        cmd('{OP_STATUS_WRITE_ARM_CMD});
        cmd('{OP_WRITE_ENABLE_CMD});
        cmd('{OP_STATUS_WRITE_CMD, 8'h00});
        cmd('{OP_WRITE_DISABLE_CMD});
        expect_bytes('{OP_STATUS_READ_CMD}, '{8'h0c});
        cmd('{OP_STATUS_WRITE_ARM_CMD});
        cmd('{OP_STATUS_WRITE_CMD, 8'h80});
        expect_bytes('{OP_STATUS_READ_CMD}, '{8'h80});
        cmd('{OP_STATUS_WRITE_ARM_CMD});
        cmd('{OP_STATUS_WRITE_CMD, 8'h00});
        expect_bytes('{OP_STATUS_READ_CMD}, '{8'h00, 8'h00});
        cmd('{OP_SECTOR_ERASE, 8'h5a, 8'h0a, 8'hbc});
        `CHECK(status_busy, 1'b0)
        $display("test protect done");
        cmd('{OP_WRITE_ENABLE_CMD});
        cmd('{OP_SECTOR_ERASE, 8'ha5, 8'h0a, 8'hbc});
        repeat (20) @(posedge clk_sys);
        clk_en <= 1'b0;
        repeat (40) @(posedge clk_sys);
        clk_en <= 1'b1;
        expect_bytes('{OP_STATUS_READ_CMD}, '{8'h03, 8'h03});
        wait_idle(6000);
        `CHECK(status_wel, 1'b0)
        cmd('{OP_WRITE_ENABLE_CMD});
        cmd('{OP_BYTE_PROGRAM, 8'hff, 8'h00, 8'h00, 8'h77});
        wait_idle(500);
        cmd('{OP_WRITE_ENABLE_CMD});
        cmd('{OP_AUTO_INCREMENT_PROGRAM, 8'h00, 8'h00, 8'h10, 8'h11});
        `CHECK(status_aai, 1'b1)
        wait_idle(500);
        expect_bytes('{OP_STATUS_READ_CMD}, '{8'h42});
        cmd('{OP_AUTO_INCREMENT_PROGRAM, 8'h22});
        wait_idle(500);
        cmd('{OP_WRITE_DISABLE_CMD});
        expect_bytes('{OP_STATUS_READ_CMD}, '{8'h00});
        $display("test program done");
        cmd('{OP_WRITE_ENABLE_CMD});
        cmd('{OP_BLOCK_ERASE, 8'h3c, 8'h81, 8'h23});
        wait_idle(40000);
        cmd('{OP_WRITE_ENABLE_CMD});
        cmd('{OP_AUTO_INCREMENT_PROGRAM, 8'h00, 8'hff, 8'hff, 8'h5a});
        wait_idle(500);
        `CHECK({status_aai, status_wel}, 2'b00)
        expect_bytes('{OP_READ, 8'hc3, 8'hff, 8'hfe}, '{8'hff, 8'h5a, 8'h77, 8'hff});
        expect_bytes('{OP_READ, 8'h00, 8'h00, 8'h0f}, '{8'hff, 8'h11, 8'h22, 8'hff});
        expect_bytes('{OP_ID_READ_A, 8'h00, 8'h00, 8'h01},
            '{device_id, maker_id, device_id});
        expect_bytes('{OP_ID_READ_B, 8'h00, 8'h00, 8'h00}, '{maker_id, device_id});
        $display("test read done");
        end_of_test();
    end
endmodule
